// [hdl/rxcs_pkg.sv]
package rxcs_pkg;

  localparam int          APB_AW          = 8;
  localparam int          DATA_W          = 32;

  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_BOND        = 8'h04;
  localparam logic [7:0]  OFS_STAT        = 8'h08;
  localparam logic [7:0]  OFS_FWDCNT      = 8'h0c;

  // Control register field positions
  localparam int          CT_PCS_LO       = 0;
  localparam int          CT_PCS_HI       = 1;
  localparam int          CT_RM_EN        = 2;
  localparam int          CT_LOOPBACK     = 3;
  localparam int          CT_BONDED       = 4;
  localparam int          CT_DESER2       = 5;
  localparam int          CT_CH_PLL_CMU   = 6;
  localparam int          CT_REF_NET      = 7;
  localparam int          CT_REF_FWD      = 8;
  localparam int          CT_BANK_TX_PLL  = 9;
  localparam int          CT_W            = 10;

  localparam logic [1:0]  PCS_STD         = 2'h0;
  localparam logic [1:0]  PCS_TENG        = 2'h1;
  localparam logic [1:0]  PCS_NONE        = 2'h2;

  localparam logic [CT_W-1:0] CTRL_RST    = 10'h000;

  localparam int          BOND_W          = 3;
  localparam logic [2:0]  BOND_RST        = 3'h1;
  localparam logic [2:0]  BOND_ALL        = 3'h6;

  // Status register field positions
  localparam int          ST_RX_OK        = 0;
  localparam int          ST_BOND_OK      = 1;
  localparam int          ST_BOND_ERR     = 2;

  localparam int          FWDCNT_W        = 16;

endpackage : rxcs_pkg

// [hdl/rxcs_clock_select.sv]
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Operation
// - CDR divides recovered serial clock into recovered parallel clock; deserializer gets both
// - Standard receiver PCS uses recovered and divider parallel clocks, bonded or not
// - Without rate matcher, word aligner and decoder run on recovered clock
// - Rate-match FIFO writes on recovered clock, reads on divider clock
// - With rate matcher, decoder and byte deserializer write run on divider clock
// - Byte deserializer read clock is write clock divided by one or two
// - Byte ordering and phase FIFO write use divided clock, forwarded to fabric
// - 10G receiver PCS runs on recovered clock in regular operation
// - 10G receiver PCS runs on divider clock in loopback
// - Bonded channels take divider clock from central divider
// - Channel PLL used as transmit multiplier PLL makes receiver unusable
// - Six-channel bonding only with bank tank or fractional transmit PLL
// - PCS-less CDR reference comes from input refclk or bank reference network
// - PCS-less channel forwards recovered parallel clock directly to fabric
// - Transmit interface clock is forwarded to fabric
// - Receive interface clock is recovered without rate matcher, else transmit side
// - Input refclk reaches fabric only when forwarding is enabled
// - Forwarded receive clock is line rate divided by deserialization factor
module rxcs_clock_select #(
  parameter int SER_DIV = 10
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rxcs_pkg::APB_AW-1:0] paddr,
  input  wire logic [rxcs_pkg::DATA_W-1:0] pwdata,
  output logic      [rxcs_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        ser_tick,
  input  wire logic                        cdiv_local_tick,
  input  wire logic                        cdiv_central_tick,
  input  wire logic                        tx_if_tick,
  input  wire logic                        refclk_in_tick,
  input  wire logic                        refclk_net_tick,
  input  wire logic                        fab_rxpcf_rd_tick,
  output logic                             des_ser_tick,
  output logic                             des_par_tick,
  output logic                             wa_tick,
  output logic                             rmf_wr_tick,
  output logic                             rmf_rd_tick,
  output logic                             dec_tick,
  output logic                             bds_wr_tick,
  output logic                             bds_rd_tick,
  output logic                             bo_tick,
  output logic                             rxpcf_wr_tick,
  output logic                             rxpcf_rd_tick,
  output logic                             teng_tick,
  output logic                             cdr_ref_tick,
  output logic                             fab_rx_clk_tick,
  output logic                             fab_tx_clk_tick,
  output logic                             fab_refclk_tick
);

  localparam int SDW = $clog2(SER_DIV + 1);

  function automatic logic pick(input logic sel, input logic a, input logic b);
    pick = sel ? b : a;
  endfunction : pick

  logic [rxcs_pkg::CT_W-1:0]     ctrl_r;
  logic [rxcs_pkg::BOND_W-1:0]   bond_r;
  logic                          bond_err_r;
  logic [rxcs_pkg::FWDCNT_W-1:0] fwdcnt_r;
  logic [SDW-1:0]                ser_cnt_r;
  logic                          rec_tick;
  logic                          bds_half_r;
  logic                          bds_rd_nxt;

  logic [1:0]                    pcs_type;
  logic                          rm_en;
  logic                          rx_ok;
  logic                          bond_ok;
  logic                          rx_run;
  logic                          std_on;
  logic                          teng_on;
  logic                          none_on;
  logic                          cdiv_tick;
  logic                          bds_wr_nxt;
  logic                          fab_rx_nxt;

  logic                          wr_acc;
  logic                          bond_bad;

  assign pcs_type  = ctrl_r[rxcs_pkg::CT_PCS_HI:rxcs_pkg::CT_PCS_LO];
  assign rm_en     = ctrl_r[rxcs_pkg::CT_RM_EN];
  // Channel PLL lent to transmit leaves no CDR for receive
  assign rx_ok     = ~ctrl_r[rxcs_pkg::CT_CH_PLL_CMU];
  // Full-bank bonding needs the bank transmit PLL selected
  assign bond_bad  = ctrl_r[rxcs_pkg::CT_BONDED] && (bond_r == rxcs_pkg::BOND_ALL)
                     && ~ctrl_r[rxcs_pkg::CT_BANK_TX_PLL];
  assign bond_ok   = ~bond_bad;
  assign rx_run    = rx_ok && bond_ok;
  assign std_on    = rx_run && (pcs_type == rxcs_pkg::PCS_STD);
  assign teng_on   = rx_run && (pcs_type == rxcs_pkg::PCS_TENG);
  assign none_on   = rx_run && (pcs_type == rxcs_pkg::PCS_NONE);
  assign cdiv_tick = pick(ctrl_r[rxcs_pkg::CT_BONDED], cdiv_local_tick,
                          cdiv_central_tick);
  assign bds_wr_nxt = std_on && pick(rm_en, rec_tick, cdiv_tick);
  // Factor two passes every second write edge
  assign bds_rd_nxt = bds_wr_nxt && (~ctrl_r[rxcs_pkg::CT_DESER2] || bds_half_r);
  // Rate matcher moves the interface onto the transmit-side clock
  assign fab_rx_nxt = (std_on && bds_rd_nxt)
                      || (teng_on && pick(ctrl_r[rxcs_pkg::CT_LOOPBACK], rec_tick, cdiv_tick))
                      || (none_on && rec_tick);

  // Zero-wait slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= rxcs_pkg::CTRL_RST;
      bond_r <= rxcs_pkg::BOND_RST;
    end else if (wr_acc) begin
      if (paddr == rxcs_pkg::OFS_CTRL) begin
        ctrl_r <= pwdata[rxcs_pkg::CT_W-1:0];
      end
      if (paddr == rxcs_pkg::OFS_BOND) begin
        bond_r <= pwdata[rxcs_pkg::BOND_W-1:0];
      end
    end
  end

  // Sticky error, set beats a same-cycle write-one clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bond_err_r <= 1'b0;
    end else if (bond_bad) begin
      bond_err_r <= 1'b1;
    end else if (wr_acc && (paddr == rxcs_pkg::OFS_STAT)
                 && pwdata[rxcs_pkg::ST_BOND_ERR]) begin
      bond_err_r <= 1'b0;
    end
  end

  always_comb begin
    prdata  = '0;
    pslverr = 1'b0;
    case (paddr)
      rxcs_pkg::OFS_CTRL:   prdata[rxcs_pkg::CT_W-1:0] = ctrl_r;
      rxcs_pkg::OFS_BOND:   prdata[rxcs_pkg::BOND_W-1:0] = bond_r;
      rxcs_pkg::OFS_STAT: begin
        prdata[rxcs_pkg::ST_RX_OK]    = rx_ok;
        prdata[rxcs_pkg::ST_BOND_OK]  = bond_ok;
        prdata[rxcs_pkg::ST_BOND_ERR] = bond_err_r;
      end
      rxcs_pkg::OFS_FWDCNT: prdata[rxcs_pkg::FWDCNT_W-1:0] = fwdcnt_r;
      default:              pslverr = psel && penable;
    endcase
  end

  // Recovered parallel clock from the serial clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_cnt_r <= '0;
    end else if (ser_tick && rx_ok) begin
      ser_cnt_r <= (ser_cnt_r == SDW'(SER_DIV - 1)) ? '0 : ser_cnt_r + 1'b1;
    end
  end
  assign rec_tick = ser_tick && rx_ok && (ser_cnt_r == SDW'(SER_DIV - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bds_half_r <= 1'b0;
    end else if (~ctrl_r[rxcs_pkg::CT_DESER2]) begin
      bds_half_r <= 1'b0;
    end else if (bds_wr_nxt) begin
      bds_half_r <= ~bds_half_r;
    end
  end

  // Forwarded receive edges, readable to check the rate
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fwdcnt_r <= '0;
    end else if (fab_rx_nxt) begin
      fwdcnt_r <= fwdcnt_r + 1'b1;
    end
  end

  // All clock edges leave through one register stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      des_ser_tick    <= 1'b0;
      des_par_tick    <= 1'b0;
      wa_tick         <= 1'b0;
      rmf_wr_tick     <= 1'b0;
      rmf_rd_tick     <= 1'b0;
      dec_tick        <= 1'b0;
      bds_wr_tick     <= 1'b0;
      bds_rd_tick     <= 1'b0;
      bo_tick         <= 1'b0;
      rxpcf_wr_tick   <= 1'b0;
      rxpcf_rd_tick   <= 1'b0;
      teng_tick       <= 1'b0;
      cdr_ref_tick    <= 1'b0;
      fab_rx_clk_tick <= 1'b0;
      fab_tx_clk_tick <= 1'b0;
      fab_refclk_tick <= 1'b0;
    end else begin
      des_ser_tick    <= ser_tick && rx_ok;
      des_par_tick    <= rec_tick;
      wa_tick         <= std_on && ~rm_en && rec_tick;
      rmf_wr_tick     <= std_on && rm_en && rec_tick;
      rmf_rd_tick     <= std_on && rm_en && cdiv_tick;
      dec_tick        <= std_on && pick(rm_en, rec_tick, cdiv_tick);
      bds_wr_tick     <= bds_wr_nxt;
      bds_rd_tick     <= bds_rd_nxt;
      bo_tick         <= std_on && bds_rd_nxt;
      rxpcf_wr_tick   <= std_on && bds_rd_nxt;
      rxpcf_rd_tick   <= std_on && fab_rxpcf_rd_tick;
      teng_tick       <= teng_on && pick(ctrl_r[rxcs_pkg::CT_LOOPBACK],
                                         rec_tick, cdiv_tick);
      cdr_ref_tick    <= none_on && pick(ctrl_r[rxcs_pkg::CT_REF_NET],
                                         refclk_in_tick, refclk_net_tick);
      fab_rx_clk_tick <= fab_rx_nxt;
      fab_tx_clk_tick <= tx_if_tick;
      fab_refclk_tick <= ctrl_r[rxcs_pkg::CT_REF_FWD] && refclk_in_tick;
    end
  end

endmodule : rxcs_clock_select

// [tb/rxcs_clock_select_assertions.sv]
`timescale 1ns/1ps
module rxcs_clock_select_assertions (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        cdiv_local_tick,
  input wire logic        cdiv_central_tick,
  input wire logic        tx_if_tick,
  input wire logic        refclk_in_tick,
  input wire logic        refclk_net_tick,
  input wire logic        fab_rxpcf_rd_tick,
  input wire logic        rmf_wr_tick,
  input wire logic        rxpcf_rd_tick,
  input wire logic        cdr_ref_tick,
  input wire logic        des_ser_tick,
  input wire logic        des_par_tick,
  input wire logic        wa_tick,
  input wire logic        rmf_rd_tick,
  input wire logic        dec_tick,
  input wire logic        bds_wr_tick,
  input wire logic        bds_rd_tick,
  input wire logic        bo_tick,
  input wire logic        rxpcf_wr_tick,
  input wire logic        teng_tick,
  input wire logic        fab_rx_clk_tick,
  input wire logic        fab_tx_clk_tick,
  input wire logic        fab_refclk_tick
);
  logic [9:0] c_r;
  logic       cdiv_sel;
  // Shadow of the control word, so config-gated relations can be judged
  assign cdiv_sel = c_r[4] ? cdiv_central_tick : cdiv_local_tick;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      c_r <= rxcs_pkg::CTRL_RST;
    end else if (psel && penable && pwrite && paddr == rxcs_pkg::OFS_CTRL) begin
      c_r <= pwdata[9:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wa_on_rec_a: assert property (wa_tick |-> des_par_tick)
    else $error("aligner tick without recovered tick");
  rmf_rd_src_a: assert property (rmf_rd_tick |-> $past(cdiv_sel))
    else $error("rate match read not on divider clock");
  dec_rm_src_a: assert property (dec_tick && $past(c_r[2]) |-> bds_wr_tick && $past(cdiv_sel))
    else $error("decoder not on divider clock");
  bds_full_a: assert property (bds_wr_tick && !$past(c_r[5]) |-> bds_rd_tick)
    else $error("byte deserializer read missing");
  div_fwd_a: assert property (bds_rd_tick && $past(c_r[1:0]) == 2'h0 |->
    bo_tick && rxpcf_wr_tick && fab_rx_clk_tick) else $error("divided clock not shared");
  teng_src_a: assert property (teng_tick |-> ($past(c_r[3]) ? $past(cdiv_sel) : des_par_tick))
    else $error("10G blocks on wrong clock");
  cmu_no_rx_a: assert property ($past(c_r[6]) |-> !des_ser_tick && !des_par_tick)
    else $error("receiver runs while channel PLL multiplies");
  pcsless_fwd_a: assert property ($past(c_r[1:0]) == 2'h2 && !$past(c_r[4]) |->
    fab_rx_clk_tick == des_par_tick) else $error("recovered clock not forwarded");
  refclk_fwd_a: assert property (fab_refclk_tick |-> $past(refclk_in_tick) && $past(c_r[8]))
    else $error("refclk forwarded while disabled");
  tx_fwd_a: assert property (tx_if_tick |=> fab_tx_clk_tick)
    else $error("transmit clock not forwarded");
  rmf_wr_src_a: assert property (rmf_wr_tick |-> des_par_tick && $past(c_r[2]))
    else $error("rate match write not on recovered clock");
  pcf_rd_src_a: assert property (rxpcf_rd_tick |-> $past(fab_rxpcf_rd_tick))
    else $error("phase FIFO read not on fabric clock");
  cdr_ref_src_a: assert property (cdr_ref_tick |-> $past(c_r[1:0]) == 2'h2
    && ($past(c_r[7]) ? $past(refclk_net_tick) : $past(refclk_in_tick)))
    else $error("CDR reference from wrong source");
  cover property (teng_tick && $past(c_r[3]));
  cover property (bds_wr_tick && !bds_rd_tick);
  cover property (fab_refclk_tick);
endmodule : rxcs_clock_select_assertions

bind rxcs_clock_select rxcs_clock_select_assertions i_rxcs_chk (.*);

// [tb/rxcs_fabric_model.sv]
`timescale 1ns/1ps
module rxcs_fabric_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      rd_tick
);
  logic [1:0] div_r;
  // Fabric read clock for the phase FIFO, a third of clk_sys, unrelated to rx rates
  // PCS-less decode, detect and management clocks are fabric work, not modelled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    end
  end
  assign rd_tick = (div_r == 2'h1);
endmodule : rxcs_fabric_model

// [tb/tb_rxcs_clock_select.sv]
`timescale 1ns/1ps
module tb_rxcs_clock_select;
  localparam int DIV = 3;
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ser_tick = 1'b0, cdiv_local_tick = 1'b0, cdiv_central_tick = 1'b0;
  logic        tx_if_tick = 1'b0, refclk_in_tick = 1'b0, refclk_net_tick = 1'b0;
  logic        pready, pslverr, fab_rxpcf_rd_tick, err_l;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q, fc, r = 32'h00010abc;
  logic [9:0]  cfg;
  logic [9:0]  cfgs [10] = '{10'h000, 10'h014, 10'h020, 10'h024, 10'h001,
                             10'h219, 10'h082, 10'h182, 10'h040, 10'h003};
  int          n_mismatch = 0, checks = 0, ser_n = 0, ph = 0, fwd = 0;
  rxcs_clock_select #(.SER_DIV(DIV)) i_rxcs_clock_select (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ser_tick, .cdiv_local_tick, .cdiv_central_tick, .tx_if_tick, .refclk_in_tick,
    .refclk_net_tick, .fab_rxpcf_rd_tick, .des_ser_tick(), .des_par_tick(), .wa_tick(),
    .rmf_wr_tick(), .rmf_rd_tick(), .dec_tick(), .bds_wr_tick(), .bds_rd_tick(), .bo_tick(),
    .rxpcf_wr_tick(), .rxpcf_rd_tick(), .teng_tick(), .cdr_ref_tick(), .fab_rx_clk_tick(),
    .fab_tx_clk_tick(), .fab_refclk_tick());
  rxcs_fabric_model i_rxcs_fabric_model (.clk_sys, .rst, .rd_tick(fab_rxpcf_rd_tick));
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Sample settled answer mid-cycle, commit at the following rising edge
    do begin
      @(negedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      end_of_test;
    end
    q = prdata;
    err_l = pslverr;
    @(posedge clk_sys);
    {psel, penable} <= 2'h0;
  endtask : apb
  // Reference of the forwarded rx clock; bonding stays legal while traffic runs
  task automatic model(input logic s, input logic l, input logic c);
    logic rec, src;
    rec = 1'b0;
    if (!cfg[6] && s) begin
      ser_n = (ser_n + 1) % DIV;
      rec = (ser_n == 0);
    end
    case (cfg[1:0])
      2'h0: src = cfg[2] ? (cfg[4] ? c : l) : rec;
      2'h1: src = cfg[3] ? (cfg[4] ? c : l) : rec;
      2'h2: src = rec;
      default: src = 1'b0;
    endcase
    if (!cfg[5]) begin
      ph = 0;
    end
    if (cfg[6]) begin
      src = 1'b0;
    end
    if (cfg[1:0] == 2'h0 && src && cfg[5]) begin
      ph = 1 - ph;
      src = (ph == 0);
    end
    fwd += src;
  endtask : model
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, rxcs_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h00000000);
    apb(1'b0, rxcs_pkg::OFS_BOND, 32'h0);
    chk(q, 32'h00000001);
    apb(1'b0, 8'h10, 32'h0);
    chk({q[30:0], err_l}, 32'h00000001);
    apb(1'b1, rxcs_pkg::OFS_BOND, 32'h6);
    apb(1'b1, rxcs_pkg::OFS_CTRL, 32'h10);
    apb(1'b0, rxcs_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h00000005);
    apb(1'b1, rxcs_pkg::OFS_CTRL, 32'h210);
    apb(1'b1, rxcs_pkg::OFS_STAT, 32'h4);
    apb(1'b0, rxcs_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h00000003);
    apb(1'b1, rxcs_pkg::OFS_BOND, 32'h1);
    foreach (cfgs[i]) begin
      cfg = cfgs[i];
      apb(1'b1, rxcs_pkg::OFS_CTRL, {22'h0, cfg});
      apb(1'b0, rxcs_pkg::OFS_STAT, 32'h0);
      chk(q, {30'h0, 1'b1, !cfg[6]});
      apb(1'b0, rxcs_pkg::OFS_FWDCNT, 32'h0);
      fc = q;
      fwd = 0;
      repeat (80) begin
        @(posedge clk_sys);
        r = xs(r);
        {ser_tick, cdiv_local_tick, cdiv_central_tick, tx_if_tick, refclk_in_tick,
         refclk_net_tick} <= r[5:0];
        model(r[5], r[4], r[3]);
      end
      @(posedge clk_sys);
      {ser_tick, cdiv_local_tick, cdiv_central_tick, tx_if_tick, refclk_in_tick,
       refclk_net_tick} <= 6'h00;
      apb(1'b0, rxcs_pkg::OFS_FWDCNT, 32'h0);
      chk((q - fc) & 32'h0000ffff, fwd);
    end
    end_of_test;
  end
endmodule : tb_rxcs_clock_select
